// file: verilog/tdm_bus_stream_rate_config.sv
// TDM bus interface: stream-rate, termination and timeslot selection over AXI4-Lite.
// Assumes bus bit clock, frame sync and stream data arrive asynchronously on pins.
// Notes on behaviour
// - Thirty-two streams, 8.192 MHz default bit clock
// - Full rate gives 128 slots per frame
// - Address: stream byte high, slot byte low
// - Letter E enables termination, D disables
// - Only streams 0-15 may run slower
// - Four rate fields, one per four streams
// - Rate codes: 0=2.048, 1=4.096, 2=8.192
// - After reset all streams run full rate
// - Reduced rate rejects slots beyond its count
// - Slot limit 1Fh at 2.048, 3Fh at 4.096
module tdm_bus_stream_rate_config (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// AXI4-Lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// TDM bus pins
	input  wire logic        bus_bit_clk,
	input  wire logic        bus_frame_sync,
	input  wire logic [31:0] bus_data,
	output logic             term_en,
	// Captured timeslot
	output logic [7:0]       slot_sample,
	output logic             slot_sample_valid
);
	logic [1:0]                   rst_q;
	logic                         rst_n;
	logic [2:0]                   clk_sync;
	logic [1:0]                   fs_sync;
	logic [31:0]                  data_s1;
	logic [31:0]                  data_s2;
	logic                         bit_tick;
	logic                         frame_tick;
	logic [31:0][1:0]             stream_rate;

	logic                         aw_full, w_full, next_aw_full, next_w_full;
	logic [3:0]                   aw_addr, next_aw_addr;
	logic [31:0]                  w_data, next_w_data;
	logic [3:0]                   w_strb, next_w_strb;
	logic                         next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]                   next_bresp, next_rresp;
	logic [31:0]                  next_rdata;
	logic                         do_write, do_read;

	logic                         next_term_en;
	tdm_pkg::tdm_rate_cfg_s       rate_cfg, next_rate_cfg;
	tdm_pkg::tdm_slot_addr_s      sel, next_sel, wr_sel;
	logic                         slot_ok, next_slot_ok, slot_rej, next_slot_rej;
	logic                         sample_new, next_sample_new;
	logic                         rate_written, next_rate_written;
	logic [7:0]                   slot_limit;
	logic                         rate_bad;

	// Reset leaves through two flops so release is clean in clk's domain
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	// Pin synchronisers; only stage two and beyond feed logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sync <= 3'h0;
			fs_sync  <= 2'h0;
			data_s1  <= 32'h0;
			data_s2  <= 32'h0;
		end else begin
			clk_sync <= {clk_sync[1:0], bus_bit_clk};
			fs_sync  <= {fs_sync[0], bus_frame_sync};
			data_s1  <= bus_data;
			data_s2  <= data_s1;
		end
	end
	// bit clock edge found by sampling
	assign bit_tick   = clk_sync[1] & ~clk_sync[2];
	assign frame_tick = fs_sync[1];

	// group field per stream, upper streams full rate
	generate
		for (genvar s = 0; s < tdm_pkg::NUM_STREAMS; s++) begin : g_rate
			if (s < tdm_pkg::RATE_STREAMS)
				assign stream_rate[s] = rate_cfg.grp[s / 4];
			else
				assign stream_rate[s] = tdm_pkg::RATE_8M;
		end
	endgenerate

	// slot limit from the addressed stream's rate
	always_comb begin
		wr_sel = {w_data[15:8], w_data[7:0]};
		case (stream_rate[wr_sel.stream[4:0]])
			tdm_pkg::RATE_2M: slot_limit = tdm_pkg::MAX_SLOT_2M;
			tdm_pkg::RATE_4M: slot_limit = tdm_pkg::MAX_SLOT_4M;
			default:          slot_limit = tdm_pkg::MAX_SLOT_8M;
		endcase
		// code 3 is not a rate
		rate_bad = (w_data[1:0] == 2'h3) || (w_data[3:2] == 2'h3) ||
			(w_data[5:4] == 2'h3) || (w_data[7:6] == 2'h3);
	end

	assign do_write = aw_full & w_full & ~s_axi_bvalid;
	assign do_read  = s_axi_arvalid & s_axi_arready;

	always_comb begin
		next_aw_full      = aw_full;
		next_w_full       = w_full;
		next_aw_addr      = aw_addr;
		next_w_data       = w_data;
		next_w_strb       = w_strb;
		next_bvalid       = s_axi_bvalid;
		next_bresp        = s_axi_bresp;
		next_rvalid       = s_axi_rvalid;
		next_rdata        = s_axi_rdata;
		next_rresp        = s_axi_rresp;
		next_term_en      = term_en;
		next_rate_cfg     = rate_cfg;
		next_rate_written = rate_written;
		next_sel          = sel;
		next_slot_ok      = slot_ok;
		next_slot_rej     = slot_rej;
		next_sample_new   = sample_new;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = tdm_pkg::RESP_OKAY;
			case (aw_addr)
				tdm_pkg::OFF_TERM: begin
					if (w_strb[0] && w_data[7:0] == tdm_pkg::TERM_ON_CHAR)
						next_term_en = 1'b1;
					else if (w_strb[0] && w_data[7:0] == tdm_pkg::TERM_OFF_CHAR)
						next_term_en = 1'b0;
					else
						next_bresp = tdm_pkg::RESP_SLVERR;
				end
				tdm_pkg::OFF_RATE: begin
					if (w_strb[0] && !rate_bad) begin
						next_rate_cfg     = w_data[7:0];
						next_rate_written = 1'b1;
					end else
						next_bresp = tdm_pkg::RESP_SLVERR;
				end
				tdm_pkg::OFF_SLOT: begin
					if (w_strb[1:0] == 2'h3 && wr_sel.stream <= tdm_pkg::MAX_STREAM &&
						wr_sel.slot <= slot_limit) begin
						next_sel      = wr_sel;
						next_slot_ok  = 1'b1;
						next_slot_rej = 1'b0;
					end else begin
						next_slot_rej = 1'b1;
						next_bresp    = tdm_pkg::RESP_SLVERR;
					end
				end
				default: next_bresp = tdm_pkg::RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (do_read) begin
			next_rvalid = 1'b1;
			next_rresp  = tdm_pkg::RESP_OKAY;
			case (s_axi_araddr)
				tdm_pkg::OFF_TERM:   next_rdata = {31'h0, term_en};
				tdm_pkg::OFF_RATE:   next_rdata = {24'h0, rate_cfg};
				tdm_pkg::OFF_SLOT:   next_rdata = {16'h0, sel};
				tdm_pkg::OFF_STATUS: begin
					next_rdata      = {16'h0, slot_sample, 5'h0, sample_new, slot_rej, slot_ok};
					next_sample_new = 1'b0;
				end
				default: begin
					next_rdata = 32'h0;
					next_rresp = tdm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// A sample landing with the clearing read still counts
		if (slot_sample_valid)
			next_sample_new = 1'b1;
		next_awready = ~next_aw_full & ~next_bvalid;
		next_wready  = ~next_w_full & ~next_bvalid;
		next_arready = ~next_rvalid;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tdm_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= tdm_pkg::RESP_OKAY;
			term_en       <= 1'b0;
			rate_cfg      <= tdm_pkg::RATE_RESET;
			rate_written  <= 1'b0;
			sel           <= tdm_pkg::SLOT_RESET;
			slot_ok       <= 1'b0;
			slot_rej      <= 1'b0;
			sample_new    <= 1'b0;
		end else begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			term_en       <= next_term_en;
			rate_cfg      <= next_rate_cfg;
			rate_written  <= next_rate_written;
			sel           <= next_sel;
			slot_ok       <= next_slot_ok;
			slot_rej      <= next_slot_rej;
			sample_new    <= next_sample_new;
		end
	end

	tdm_slot_tap u_tap (
		.clk          (clk),
		.rst_n        (rst_n),
		.bit_tick     (bit_tick),
		.frame_tick   (frame_tick),
		.data_bit     (data_s2[sel.stream[4:0]]),
		.rate         (stream_rate[sel.stream[4:0]]),
		.slot         (sel.slot[6:0]),
		.sample       (slot_sample),
		.sample_valid (slot_sample_valid)
	);

	chk_term_on: assert property (@(posedge clk) disable iff (!rst_n)
		do_write && aw_addr == tdm_pkg::OFF_TERM && w_strb[0] && w_data[7:0] == tdm_pkg::TERM_ON_CHAR
		|=> term_en && s_axi_bvalid) else $error("termination not enabled by E");
	chk_term_off: assert property (@(posedge clk) disable iff (!rst_n)
		do_write && aw_addr == tdm_pkg::OFF_TERM && w_strb[0] && w_data[7:0] == tdm_pkg::TERM_OFF_CHAR
		|=> !term_en) else $error("termination not disabled by D");
	chk_rate_default: assert property (@(posedge clk) disable iff (!rst_n)
		!rate_written |-> rate_cfg == tdm_pkg::RATE_RESET) else $error("rate moved without a write");
	chk_rate_codes: assert property (@(posedge clk) disable iff (!rst_n)
		rate_cfg.grp[0] != 2'h3 && rate_cfg.grp[1] != 2'h3 && rate_cfg.grp[2] != 2'h3
		&& rate_cfg.grp[3] != 2'h3) else $error("illegal rate code stored");
	chk_upper_full: assert property (@(posedge clk) disable iff (!rst_n)
		stream_rate[16] == tdm_pkg::RATE_8M && stream_rate[31] == tdm_pkg::RATE_8M)
		else $error("upper stream not at full rate");
	chk_group_map: assert property (@(posedge clk) disable iff (!rst_n)
		stream_rate[5] == rate_cfg.grp[1] && stream_rate[15] == rate_cfg.grp[3])
		else $error("stream group mapping wrong");
	chk_stream_reject: assert property (@(posedge clk) disable iff (!rst_n)
		do_write && aw_addr == tdm_pkg::OFF_SLOT && w_data[15:8] > tdm_pkg::MAX_STREAM
		|=> slot_rej && $stable(sel) && s_axi_bresp == tdm_pkg::RESP_SLVERR)
		else $error("bad stream accepted");
	chk_slot_limit: assert property (@(posedge clk) disable iff (!rst_n)
		do_write && aw_addr == tdm_pkg::OFF_SLOT && w_data[15:8] < 8'h04 &&
		rate_cfg.grp[0] == tdm_pkg::RATE_2M && w_data[7:0] > tdm_pkg::MAX_SLOT_2M
		|=> slot_rej) else $error("slot beyond 2.048 limit accepted");
	chk_resp_hold: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_hold: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cov_term_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(term_en));
	cov_legacy_4m: cover property (@(posedge clk) disable iff (!rst_n) rate_cfg == 8'h55);
	cov_reject: cover property (@(posedge clk) disable iff (!rst_n) $rose(slot_rej));
	cov_sample: cover property (@(posedge clk) disable iff (!rst_n) slot_sample_valid);
endmodule

// file: verilog/tdm_pkg.sv
// Shared constants and types for the TDM bus stream-rate block.
// Assumes a 50 MHz system clock and an AXI4-Lite register port.
package tdm_pkg;
	localparam int          NUM_STREAMS    = 32;
	localparam int          RATE_STREAMS   = 16;
	localparam int          NUM_GROUPS     = 4;
	localparam int          SAMPLE_BITS    = 8;
	localparam int          BUS_RATE_KHZ   = 8192;
	localparam int          FRAME_US       = 125;
	localparam int          BITS_PER_FRAME = BUS_RATE_KHZ * FRAME_US / 1000;
	localparam int          BIT_CNT_W      = $clog2(BITS_PER_FRAME);
	localparam int          ADDR_W         = 4;
	localparam logic [1:0]  RATE_2M        = 2'h0;
	localparam logic [1:0]  RATE_4M        = 2'h1;
	localparam logic [1:0]  RATE_8M        = 2'h2;
	localparam logic [7:0]  RATE_RESET     = 8'haa;
	localparam logic [7:0]  MAX_STREAM     = 8'h1f;
	localparam logic [7:0]  MAX_SLOT_2M    = 8'h1f;
	localparam logic [7:0]  MAX_SLOT_4M    = 8'h3f;
	localparam logic [7:0]  MAX_SLOT_8M    = 8'h7f;
	localparam logic [7:0]  TERM_ON_CHAR   = 8'h45;
	localparam logic [7:0]  TERM_OFF_CHAR  = 8'h44;
	localparam logic [3:0]  OFF_TERM       = 4'h0;
	localparam logic [3:0]  OFF_RATE       = 4'h4;
	localparam logic [3:0]  OFF_SLOT       = 4'h8;
	localparam logic [3:0]  OFF_STATUS     = 4'hc;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam logic [15:0] SLOT_RESET     = 16'h0000;

	typedef struct packed {
		logic [7:0] stream;
		logic [7:0] slot;
	} tdm_slot_addr_s;

	typedef struct packed {
		logic [3:0][1:0] grp;
	} tdm_rate_cfg_s;
endpackage

// file: verilog/tdm_slot_tap.sv
// Captures one 8-bit timeslot sample per frame from one serial stream.
// Assumes bit_tick marks each bus bit clock rising edge and frame_tick the frame's first edge.
module tdm_slot_tap (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bus timing and data
	input  wire logic       bit_tick,
	input  wire logic       frame_tick,
	input  wire logic       data_bit,
	// Selection
	input  wire logic [1:0] rate,
	input  wire logic [6:0] slot,
	// Captured sample
	output logic      [7:0] sample,
	output logic            sample_valid
);
	logic [tdm_pkg::BIT_CNT_W-1:0] cnt;
	logic [tdm_pkg::BIT_CNT_W-1:0] next_cnt;
	logic [tdm_pkg::BIT_CNT_W-1:0] cnt_now;
	logic [tdm_pkg::BIT_CNT_W-1:0] lane;
	logic [6:0]                    shift;
	logic [6:0]                    next_shift;
	logic [7:0]                    next_sample;
	logic                          next_valid;
	logic                          on_bit;

	always_comb begin
		cnt_now     = frame_tick ? '0 : tdm_pkg::BIT_CNT_W'(cnt + 1'b1);
		next_cnt    = cnt;
		next_shift  = shift;
		next_sample = sample;
		next_valid  = 1'b0;
		case (rate)
			tdm_pkg::RATE_8M: begin
				lane   = cnt_now;
				on_bit = 1'b1;
			end
			tdm_pkg::RATE_4M: begin
				lane   = {1'b0, cnt_now[tdm_pkg::BIT_CNT_W-1:1]};
				on_bit = ~cnt_now[0];
			end
			default: begin
				lane   = {2'b00, cnt_now[tdm_pkg::BIT_CNT_W-1:2]};
				on_bit = (cnt_now[1:0] == 2'h0);
			end
		endcase
		if (bit_tick) begin
			next_cnt = cnt_now;
			if (on_bit && lane[tdm_pkg::BIT_CNT_W-1:3] == slot) begin
				next_shift = {shift[5:0], data_bit};
				if (lane[2:0] == 3'h7) begin
					next_sample = {shift, data_bit};
					next_valid  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt          <= '0;
			shift        <= 7'h00;
			sample       <= 8'h00;
			sample_valid <= 1'b0;
		end else begin
			cnt          <= next_cnt;
			shift        <= next_shift;
			sample       <= next_sample;
			sample_valid <= next_valid;
		end
	end

	chk_sample_single: assert property (@(posedge clk) disable iff (!rst_n)
		sample_valid |=> !sample_valid) else $error("sample pulse longer than one cycle");
	chk_frame_restart: assert property (@(posedge clk) disable iff (!rst_n)
		bit_tick && frame_tick |=> cnt == '0) else $error("frame did not restart bit count");
endmodule

// file: tb/tdm_far_end.sv
// Behavioural far-side board on the TDM bus: bit clock, frame sync and 32 data lanes.
// Assumes the bench sets rate_cfg and salt before each run_frame call.
module tdm_far_end (
	// Bus pins
	output logic                          bus_bit_clk,
	output logic                          bus_frame_sync,
	output logic [31:0]                   bus_data,
	// Scenario control
	input  wire tdm_pkg::tdm_rate_cfg_s   rate_cfg,
	input  wire logic [7:0]               salt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		bus_bit_clk = 1'b0;
		bus_frame_sync = 1'b0;
		bus_data = 32'h5a5a5a5a;
	end

	function automatic logic lane_bit(input int s, input int e);
		int         d;
		int         b;
		logic [7:0] v;
		d = (s >= 16) ? 1 : (rate_cfg.grp[s/4] == tdm_pkg::RATE_2M) ? 4 :
			(rate_cfg.grp[s/4] == tdm_pkg::RATE_4M) ? 2 : 1;
		b = e / d;
		v = {s[4:0], 3'h0} ^ 8'(b / 8) ^ salt;
		return v[7 - (b % 8)];
	endfunction

	// clock runs only within a frame
	task automatic run_frame(input int nbits);
		int e;
		int s;
		#7;
		for (e = 0; e < nbits; e++) begin
			bus_frame_sync = (e == 0);
			for (s = 0; s < 32; s++) bus_data[s] = lane_bit(s, e);
			#80 bus_bit_clk = 1'b1;
			#80 bus_bit_clk = 1'b0;
		end
		// Released lanes must not look like a held last bit
		bus_frame_sync = 1'b0;
		bus_data = ~bus_data;
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the TDM stream-rate block: AXI4-Lite registers and slot capture.
// Assumes the far-side model drives the bus pins and the design's own register map.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   clk, rst_b, term_en, slot_sample_valid;
	logic [3:0]             s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                   s_axi_rvalid, s_axi_rready;
	logic [31:0]            s_axi_wdata, s_axi_rdata, bus_data;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic                   bus_bit_clk, bus_frame_sync;
	logic [7:0]             slot_sample, got, far_salt;
	tdm_pkg::tdm_rate_cfg_s far_rate;
	int                     bad_count, checks, seed, seen_cnt;
	logic [3:0]             strb;

	tdm_bus_stream_rate_config tdm_bus_stream_rate_config_inst (.clk(clk), .rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus_bit_clk(bus_bit_clk),
		.bus_frame_sync(bus_frame_sync), .bus_data(bus_data), .term_en(term_en),
		.slot_sample(slot_sample), .slot_sample_valid(slot_sample_valid));

	tdm_far_end tdm_far_end_inst (.bus_bit_clk(bus_bit_clk), .bus_frame_sync(bus_frame_sync),
		.bus_data(bus_data), .rate_cfg(far_rate), .salt(far_salt));

	always #10 clk = ~clk;

	always @(posedge clk) begin
		if (slot_sample_valid === 1'b1) begin
			got <= slot_sample;
			seen_cnt <= seen_cnt + 1;
		end
	end

	task automatic stop_test;
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic give_up;
		bad_count++;
		stop_test;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic int div_of(input logic [7:0] cfg, input int s);
		if (s >= 16) return 1;
		case (cfg[(s/4)*2 +: 2])
			2'h0: return 4;
			2'h1: return 2;
			default: return 1;
		endcase
	endfunction

	function automatic logic [7:0] pat(input int s, input int n, input logic [7:0] k);
		return {s[4:0], 3'h0} ^ n[7:0] ^ k;
	endfunction

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic aw_done, w_done;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (aw_done && w_done && s_axi_bvalid === 1'b1) break;
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		if (n == 200) give_up;
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (!s_axi_arvalid && s_axi_rvalid === 1'b1) break;
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		if (n == 200) give_up;
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr_exp(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axi_write(a, d, r);
		check(r, er);
	endtask

	task automatic rd_exp(input logic [3:0] a, input logic [31:0] ed);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check({r, d}, {tdm_pkg::RESP_OKAY, ed});
	endtask

	task automatic capture(input logic [7:0] cfg, input int s, input int n);
		logic [31:0] d;
		logic [1:0]  r;
		int          k, c0;
		wr_exp(tdm_pkg::OFF_RATE, {24'h0, cfg}, tdm_pkg::RESP_OKAY);
		wr_exp(tdm_pkg::OFF_SLOT, {16'h0, s[7:0], n[7:0]}, tdm_pkg::RESP_OKAY);
		far_rate <= cfg;
		far_salt <= 8'($random(seed));
		@(posedge clk);
		c0 = seen_cnt;
		tdm_far_end_inst.run_frame((n + 1) * 8 * div_of(cfg, s) + 1);
		for (k = 0; k < 40 && seen_cnt == c0; k++) @(posedge clk);
		if (seen_cnt == c0) give_up;
		check(got, pat(s, n, far_salt));
		axi_read(tdm_pkg::OFF_STATUS, d, r);
		check({d[15:8], 5'h0, d[2]}, {pat(s, n, far_salt), 6'h01});
		axi_read(tdm_pkg::OFF_STATUS, d, r);
		check(d[2], 1'b0);
	endtask

	// Rate config, stream, slot and whether the selection is accepted
	logic [31:0] lim_tab [9] = '{32'h00001f01, 32'h00002000, 32'h55033f01, 32'h55034000, 32'haa0f7f01,
		32'haa0f8000, 32'h00107f01, 32'haa200000, 32'haa1f7f01};

	initial begin
		logic [31:0] d, sel;
		logic [1:0]  r;
		logic [7:0]  cfg;
		int          i;
		clk = 1'b0;
		rst_b = 1'b0;
		{s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		far_rate = 8'haa;
		far_salt = 8'h00;
		seed = 32'hc5c4;
		strb = 4'hf;
		bad_count = 0;
		checks = 0;
		seen_cnt = 0;
		sel = 32'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rd_exp(tdm_pkg::OFF_TERM, 32'h0);
		rd_exp(tdm_pkg::OFF_RATE, 32'haa);
		rd_exp(tdm_pkg::OFF_SLOT, 32'h0);
		rd_exp(tdm_pkg::OFF_STATUS, 32'h0);
		// this board sits at a cable end
		wr_exp(tdm_pkg::OFF_TERM, 32'h45, tdm_pkg::RESP_OKAY);
		check(term_en, 1'b1);
		wr_exp(tdm_pkg::OFF_TERM, 32'h58, tdm_pkg::RESP_SLVERR);
		rd_exp(tdm_pkg::OFF_TERM, 32'h1);
		wr_exp(tdm_pkg::OFF_TERM, 32'h44, tdm_pkg::RESP_OKAY);
		check(term_en, 1'b0);
		axi_write(4'h2, 32'h45, r);
		check(r, tdm_pkg::RESP_SLVERR);
		rd_exp(tdm_pkg::OFF_TERM, 32'h0);
		axi_read(4'h2, d, r);
		check({r, d}, {tdm_pkg::RESP_SLVERR, 32'h0});
		// Strobes missing a byte the register needs must leave its setting alone
		strb = 4'h2;
		wr_exp(tdm_pkg::OFF_TERM, 32'h45, tdm_pkg::RESP_SLVERR);
		check(term_en, 1'b0);
		strb = 4'he;
		wr_exp(tdm_pkg::OFF_RATE, 32'h00, tdm_pkg::RESP_SLVERR);
		rd_exp(tdm_pkg::OFF_RATE, 32'haa);
		strb = 4'h1;
		wr_exp(tdm_pkg::OFF_SLOT, 32'h0, tdm_pkg::RESP_SLVERR);
		strb = 4'hf;
		for (i = 0; i < 6; i++) begin
			cfg = {2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3),
				2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3)};
			wr_exp(tdm_pkg::OFF_RATE, {24'h0, cfg}, tdm_pkg::RESP_OKAY);
			rd_exp(tdm_pkg::OFF_RATE, {24'h0, cfg});
		end
		wr_exp(tdm_pkg::OFF_RATE, 32'ha7, tdm_pkg::RESP_SLVERR);
		rd_exp(tdm_pkg::OFF_RATE, {24'h0, cfg});
		for (i = 0; i < 9; i++) begin
			wr_exp(tdm_pkg::OFF_RATE, {24'h0, lim_tab[i][31:24]}, tdm_pkg::RESP_OKAY);
			axi_write(tdm_pkg::OFF_SLOT, {16'h0, lim_tab[i][23:8]}, r);
			check(r, lim_tab[i][0] ? tdm_pkg::RESP_OKAY : tdm_pkg::RESP_SLVERR);
			if (lim_tab[i][0]) sel = {16'h0, lim_tab[i][23:8]};
			rd_exp(tdm_pkg::OFF_SLOT, sel);
			axi_read(tdm_pkg::OFF_STATUS, d, r);
			check(d[1:0], lim_tab[i][0] ? 2'h1 : 2'h3);
		end
		capture(8'h00, 0, 31);
		capture(8'h55, 5, 63);
		capture(8'haa, 31, 127);
		capture(8'h00, 16, 3);
		for (i = 0; i < 5; i++) begin
			cfg = {2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3),
				2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3)};
			capture(cfg, $unsigned($random(seed)) % 32, $unsigned($random(seed)) % 16);
		end
		stop_test;
	end

	initial begin
		repeat (100000) @(posedge clk);
		give_up;
	end
endmodule
